// file: design/dcc_top.v
// Control and status logic for two programmable voltage comparators
`timescale 1ns/1ns
// How it works
// - Two identical channels; only channel A drives system reset.
// - Registered output plus raw analog output.
// - Disabled channel drives its pin output low.
// - Falling edge sets fall flag; rising sets rise.
// - Edge flags stay set until software clears.
// - Mode bits 5,4 enable rise/fall interrupts.
// - Control bit 6 shows positive above negative.
// - Control bit 7 enables or disables comparator.
// - Control bits 3-2 select positive hysteresis.
// - Control bits 1-0 select negative hysteresis.
// - Mode field selects response time, reset 02.
// - Channel A positive select drives pin mux.
// - Channel A negative select bits 5-4.
// - Channel B positive select bits 1-0.
// - Channel B negative select bits 5-4.
// - Channel A output feeds system reset logic.
`include "dcc_map.vh"

module dcc_top
(
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	output reg  [7:0] sfr_rdata,
	input  wire       cmp_a_core_out,
	input  wire       cmp_b_core_out,
	output wire       cmp_a_enable,
	output wire       cmp_b_enable,
	output wire [1:0] cmp_a_pos_hyst_sel,
	output wire [1:0] cmp_a_neg_hyst_sel,
	output wire [1:0] cmp_b_pos_hyst_sel,
	output wire [1:0] cmp_b_neg_hyst_sel,
	output wire [1:0] cmp_a_response_mode,
	output wire [1:0] cmp_b_response_mode,
	output wire [1:0] a_pos_input_sel,
	output wire [1:0] a_neg_input_sel,
	output wire [1:0] b_pos_input_sel,
	output wire [1:0] b_neg_input_sel,
	output wire       cmp_a_latched_out,
	output wire       cmp_b_latched_out,
	output wire       cmp_a_raw_out,
	output wire       cmp_b_raw_out,
	output wire       cmp_a_reset_src,
	output wire       cmp_a_irq,
	output wire       cmp_b_irq
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0] a_ctrl_q;
reg  [7:0] b_ctrl_q;
reg  [7:0] a_mode_q;
reg  [7:0] b_mode_q;
reg  [7:0] a_mux_q;
reg  [7:0] b_mux_q;
reg        a_rise_q;
reg        a_fall_q;
reg        b_rise_q;
reg        b_fall_q;
reg  [2:0] a_sync_q;
reg  [2:0] b_sync_q;
reg        a_rise_d;
reg        a_fall_d;
reg        b_rise_d;
reg        b_fall_d;

wire       a_en;
wire       b_en;
wire       a_state;
wire       b_state;
wire       a_rise_ev;
wire       a_fall_ev;
wire       b_rise_ev;
wire       b_fall_ev;
wire       wr_a_ctrl;
wire       wr_b_ctrl;

////////////////////////////////////////////////////////////////////////////////
// Flag update: hardware set wins over software clear

function flag_next;
	input cur;
	input set_ev;
	input wr;
	input wbit;
	begin
		if (set_ev)
			flag_next = 1'b1;
		else if (wr)
			flag_next = wbit;
		else
			flag_next = cur;
	end
endfunction

assign wr_a_ctrl = sfr_wr && (sfr_addr == `DCC_A_CTRL_ADDR);
assign wr_b_ctrl = sfr_wr && (sfr_addr == `DCC_B_CTRL_ADDR);

assign a_en = a_ctrl_q[`DCC_EN_BIT];
assign b_en = b_ctrl_q[`DCC_EN_BIT];

////////////////////////////////////////////////////////////////////////////////
// Synchronisers and edge detection; stage 0 is read only by stage 1

always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		a_sync_q <= 3'h0;
		b_sync_q <= 3'h0;
	end
	else
	begin
		a_sync_q <= {a_sync_q[1:0], cmp_a_core_out & a_en};
		b_sync_q <= {b_sync_q[1:0], cmp_b_core_out & b_en};
	end
end

assign a_state   = a_sync_q[1];
assign b_state   = b_sync_q[1];
assign a_rise_ev = a_sync_q[1] & ~a_sync_q[2];
assign a_fall_ev = ~a_sync_q[1] & a_sync_q[2];
assign b_rise_ev = b_sync_q[1] & ~b_sync_q[2];
assign b_fall_ev = ~b_sync_q[1] & b_sync_q[2];

always @*
begin
	a_rise_d = flag_next(a_rise_q, a_rise_ev, wr_a_ctrl, sfr_wdata[`DCC_RISE_BIT]);
	a_fall_d = flag_next(a_fall_q, a_fall_ev, wr_a_ctrl, sfr_wdata[`DCC_FALL_BIT]);
	b_rise_d = flag_next(b_rise_q, b_rise_ev, wr_b_ctrl, sfr_wdata[`DCC_RISE_BIT]);
	b_fall_d = flag_next(b_fall_q, b_fall_ev, wr_b_ctrl, sfr_wdata[`DCC_FALL_BIT]);
end

////////////////////////////////////////////////////////////////////////////////
// Register writes

always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		a_ctrl_q <= `DCC_CTRL_RST;
		b_ctrl_q <= `DCC_CTRL_RST;
		a_mode_q <= `DCC_MODE_RST;
		b_mode_q <= `DCC_MODE_RST;
		a_mux_q  <= `DCC_MUX_RST;
		b_mux_q  <= `DCC_MUX_RST;
		a_rise_q <= 1'b0;
		a_fall_q <= 1'b0;
		b_rise_q <= 1'b0;
		b_fall_q <= 1'b0;
	end
	else
	begin
		a_rise_q <= a_rise_d;
		a_fall_q <= a_fall_d;
		b_rise_q <= b_rise_d;
		b_fall_q <= b_fall_d;
		// Only enable and hysteresis are stored here; status bits live apart
		if (wr_a_ctrl)
			a_ctrl_q <= sfr_wdata & 8'h8F;
		if (wr_b_ctrl)
			b_ctrl_q <= sfr_wdata & 8'h8F;
		if (sfr_wr && (sfr_addr == `DCC_A_MODE_ADDR))
			a_mode_q <= sfr_wdata & `DCC_MODE_MASK;
		if (sfr_wr && (sfr_addr == `DCC_B_MODE_ADDR))
			b_mode_q <= sfr_wdata & `DCC_MODE_MASK;
		if (sfr_wr && (sfr_addr == `DCC_A_MUX_ADDR))
			a_mux_q <= sfr_wdata & `DCC_MUX_MASK;
		if (sfr_wr && (sfr_addr == `DCC_B_MUX_ADDR))
			b_mux_q <= sfr_wdata & `DCC_MUX_MASK;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read data is registered; unmapped addresses read zero

always @(posedge clk_sys)
begin
	if (!rst_n)
		sfr_rdata <= 8'h00;
	else if (sfr_rd)
	begin
		if (sfr_addr == `DCC_A_CTRL_ADDR)
			sfr_rdata <= {a_en, a_state, a_rise_q, a_fall_q, a_ctrl_q[3:0]};
		else if (sfr_addr == `DCC_B_CTRL_ADDR)
			sfr_rdata <= {b_en, b_state, b_rise_q, b_fall_q, b_ctrl_q[3:0]};
		else if (sfr_addr == `DCC_A_MODE_ADDR)
			sfr_rdata <= a_mode_q;
		else if (sfr_addr == `DCC_B_MODE_ADDR)
			sfr_rdata <= b_mode_q;
		else if (sfr_addr == `DCC_A_MUX_ADDR)
			sfr_rdata <= a_mux_q;
		else if (sfr_addr == `DCC_B_MUX_ADDR)
			sfr_rdata <= b_mux_q;
		else
			sfr_rdata <= 8'h00;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Analog core controls and outputs

assign cmp_a_enable        = a_en;
assign cmp_b_enable        = b_en;
assign cmp_a_pos_hyst_sel  = a_ctrl_q[`DCC_HYP_HI:`DCC_HYP_LO];
assign cmp_a_neg_hyst_sel  = a_ctrl_q[`DCC_HYN_HI:`DCC_HYN_LO];
assign cmp_b_pos_hyst_sel  = b_ctrl_q[`DCC_HYP_HI:`DCC_HYP_LO];
assign cmp_b_neg_hyst_sel  = b_ctrl_q[`DCC_HYN_HI:`DCC_HYN_LO];
assign cmp_a_response_mode = a_mode_q[`DCC_MD_HI:`DCC_MD_LO];
assign cmp_b_response_mode = b_mode_q[`DCC_MD_HI:`DCC_MD_LO];
assign a_pos_input_sel     = a_mux_q[`DCC_PSEL_HI:`DCC_PSEL_LO];
assign a_neg_input_sel     = a_mux_q[`DCC_NSEL_HI:`DCC_NSEL_LO];
assign b_pos_input_sel     = b_mux_q[`DCC_PSEL_HI:`DCC_PSEL_LO];
assign b_neg_input_sel     = b_mux_q[`DCC_NSEL_HI:`DCC_NSEL_LO];

// Latched output comes from flops; raw output needs no clock so it can run in stop mode
assign cmp_a_latched_out = a_state;
assign cmp_b_latched_out = b_state;
assign cmp_a_raw_out     = cmp_a_core_out & a_en;
assign cmp_b_raw_out     = cmp_b_core_out & b_en;
assign cmp_a_reset_src   = cmp_a_raw_out;

assign cmp_a_irq = (a_rise_q & a_mode_q[`DCC_RIE_BIT]) | (a_fall_q & a_mode_q[`DCC_FIE_BIT]);
assign cmp_b_irq = (b_rise_q & b_mode_q[`DCC_RIE_BIT]) | (b_fall_q & b_mode_q[`DCC_FIE_BIT]);

endmodule

// file: inc/dcc_map.vh
// Register offsets, field positions and reset values of the dual comparator control
`ifndef DCC_MAP_VH
`define DCC_MAP_VH

`define DCC_B_CTRL_ADDR   8'h9A
`define DCC_A_CTRL_ADDR   8'h9B
`define DCC_B_MODE_ADDR   8'h9C
`define DCC_A_MODE_ADDR   8'h9D
`define DCC_B_MUX_ADDR    8'h9E
`define DCC_A_MUX_ADDR    8'h9F

`define DCC_CTRL_RST      8'h00
`define DCC_MODE_RST      8'h02
`define DCC_MUX_RST       8'h00

`define DCC_EN_BIT        7
`define DCC_OUT_BIT       6
`define DCC_RISE_BIT      5
`define DCC_FALL_BIT      4
`define DCC_HYP_HI        3
`define DCC_HYP_LO        2
`define DCC_HYN_HI        1
`define DCC_HYN_LO        0

`define DCC_RIE_BIT       5
`define DCC_FIE_BIT       4
`define DCC_MD_HI         1
`define DCC_MD_LO         0

`define DCC_NSEL_HI       5
`define DCC_NSEL_LO       4
`define DCC_PSEL_HI       1
`define DCC_PSEL_LO       0

`define DCC_MODE_MASK     8'h33
`define DCC_MUX_MASK      8'h33

`endif

// file: tb/dcc_top_sva.sv
// Port assertions for the dual comparator control
`timescale 1ns/1ns
module dcc_top_sva
(
	input wire       clk_sys,
	input wire       rst_n,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire       sfr_wr,
	input wire       cmp_a_core_out,
	input wire       cmp_a_enable,
	input wire       cmp_b_enable,
	input wire [1:0] cmp_b_pos_hyst_sel,
	input wire [1:0] cmp_b_neg_hyst_sel,
	input wire [1:0] cmp_a_response_mode,
	input wire [1:0] b_pos_input_sel,
	input wire [1:0] b_neg_input_sel,
	input wire       cmp_a_latched_out,
	input wire       cmp_b_latched_out,
	input wire       cmp_a_raw_out,
	input wire       cmp_a_reset_src,
	input wire       cmp_a_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_raw_gate: assert property (cmp_a_raw_out == (cmp_a_core_out & cmp_a_enable))
		else $error("raw gate");
	chk_reset_feed: assert property (cmp_a_reset_src == cmp_a_raw_out)
		else $error("reset feed");
	chk_off_low: assert property (!cmp_b_enable [*3] |-> !cmp_b_latched_out)
		else $error("off not low");
	chk_sync_lag: assert property ((cmp_a_enable && cmp_a_core_out) [*3]
		|-> cmp_a_latched_out) else $error("sync lag");
	chk_irq_sticky: assert property (cmp_a_irq && !sfr_wr |=> cmp_a_irq)
		else $error("irq dropped");
	chk_enable_wr: assert property (sfr_wr && sfr_addr == 8'h9B
		|=> cmp_a_enable == $past(sfr_wdata[7])) else $error("enable");
	chk_hyst_wr: assert property (sfr_wr && sfr_addr == 8'h9A
		|=> {cmp_b_pos_hyst_sel, cmp_b_neg_hyst_sel} == $past(sfr_wdata[3:0]))
		else $error("hysteresis");
	chk_mode_wr: assert property (sfr_wr && sfr_addr == 8'h9D
		|=> cmp_a_response_mode == $past(sfr_wdata[1:0])) else $error("mode");
	chk_mux_wr: assert property (sfr_wr && sfr_addr == 8'h9E
		|=> {b_neg_input_sel, b_pos_input_sel} == {$past(sfr_wdata[5:4]),
		$past(sfr_wdata[1:0])}) else $error("mux");
	cov_irq: cover property (cmp_a_irq);
	cov_rise_b: cover property ($rose(cmp_b_latched_out));
	cov_gated: cover property (cmp_a_core_out && !cmp_a_enable);
endmodule
bind dcc_top dcc_top_sva dcc_top_sva_i (.*);

// file: tb/dcc_core_model.sv
// Behavioural analog core of one comparator channel
`timescale 1ns/1ns
module dcc_core_model
(
	input  wire want,
	input  wire enable,
	output wire core_out
);
	// Lag keeps changes off clock edges; an idle core floats high to expose missing gating
	assign #2 core_out = enable ? want : 1'h1;
endmodule

// file: tb/dcc_top_bench.sv
// Self-checking bench for the dual comparator control
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] %0t mismatch", $time); end end
module dcc_top_bench;
	reg        clk_sys = 1'h0;
	reg        rst_n = 1'h0;
	reg  [7:0] sfr_addr = 8'h00;
	reg  [7:0] sfr_wdata = 8'h00;
	reg        sfr_wr = 1'h0;
	reg        sfr_rd = 1'h0;
	reg        want_a = 1'h0;
	reg        want_b = 1'h0;
	wire [7:0] sfr_rdata;
	wire       cmp_a_core_out, cmp_b_core_out, cmp_a_enable, cmp_b_enable, cmp_a_irq, cmp_b_irq;
	wire       cmp_a_latched_out, cmp_b_latched_out, cmp_a_raw_out, cmp_b_raw_out, cmp_a_reset_src;
	wire [1:0] cmp_a_pos_hyst_sel, cmp_a_neg_hyst_sel, cmp_b_pos_hyst_sel, cmp_b_neg_hyst_sel;
	wire [1:0] cmp_a_response_mode, cmp_b_response_mode;
	wire [1:0] a_pos_input_sel, a_neg_input_sel, b_pos_input_sel, b_neg_input_sel;
	int        mismatches = 0;
	int        num_checks = 0;
	always #2 clk_sys = ~clk_sys;
	dcc_top dcc_top_i (.*);
	dcc_core_model ma (.want(want_a), .enable(cmp_a_enable), .core_out(cmp_a_core_out));
	dcc_core_model mb (.want(want_b), .enable(cmp_b_enable), .core_out(cmp_b_core_out));
	////////////////////////////////////////////////////////////////////////////////
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk_sys) #1;
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'h1};
		@(posedge clk_sys) #1;
		sfr_wr = 1'h0;
	endtask
	task rc(input [7:0] a, input [7:0] e);
		@(posedge clk_sys) #1;
		{sfr_addr, sfr_rd} = {a, 1'h1};
		@(posedge clk_sys) #1;
		sfr_rd = 1'h0;
		`CHK(sfr_rdata, e)
	endtask
	task settle;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task t_reset;
		rc(8'h9A, 8'h00);
		rc(8'h9B, 8'h00);
		rc(8'h9C, 8'h02);
		rc(8'h9D, 8'h02);
		rc(8'h9E, 8'h00);
		rc(8'h9F, 8'h00);
		rc(8'hA0, 8'h00);
	endtask
	task t_fields;
		reg [1:0] i;
		for (int k = 0; k < 4; k++)
		begin
			i = k[1:0];
			wr(8'h9A, {4'h4, i, ~i});
			wr(8'h9D, {6'h3F, i});
			wr(8'h9F, {2'h3, i, 2'h3, ~i});
			wr(8'h9E, {2'h3, ~i, 2'h3, i});
			wr(8'h9B, {4'h4, ~i, i});
			wr(8'h9C, {6'h3F, ~i});
			`CHK({cmp_a_pos_hyst_sel, cmp_a_neg_hyst_sel}, {~i, i})
			`CHK(cmp_b_response_mode, ~i)
			rc(8'h9C, {6'h0C, ~i});
			rc(8'h9B, {4'h0, ~i, i});
			`CHK({cmp_b_pos_hyst_sel, cmp_b_neg_hyst_sel}, {i, ~i})
			`CHK(cmp_a_response_mode, i)
			`CHK({a_neg_input_sel, a_pos_input_sel}, {i, ~i})
			`CHK({b_neg_input_sel, b_pos_input_sel}, {~i, i})
			rc(8'h9D, {6'h0C, i});
			rc(8'h9A, {4'h0, i, ~i});
		end
	endtask
	task t_edge_a;
		wr(8'h9B, 8'h80);
		wr(8'h9D, 8'h30);
		want_a = 1'h1;
		settle;
		`CHK({cmp_a_latched_out, cmp_a_raw_out, cmp_a_reset_src, cmp_a_irq}, 4'hF)
		rc(8'h9B, 8'hE0);
		want_a = 1'h0;
		settle;
		rc(8'h9B, 8'hB0);
		wr(8'h9B, 8'h80);
		rc(8'h9B, 8'h80);
		`CHK(cmp_a_irq, 1'h0)
		wr(8'h9B, 8'h00);
		want_a = 1'h1;
		settle;
		`CHK({cmp_a_latched_out, cmp_a_raw_out, cmp_a_reset_src}, 3'h0)
	endtask
	task t_edge_b;
		wr(8'h9A, 8'h80);
		wr(8'h9C, 8'h20);
		want_b = 1'h1;
		settle;
		`CHK({cmp_b_irq, cmp_b_raw_out}, 2'h3)
		want_b = 1'h0;
		settle;
		`CHK({cmp_b_irq, cmp_b_latched_out}, 2'h2)
		rc(8'h9A, 8'hB0);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys);
		#1;
		rst_n = 1'h1;
		t_reset;
		t_fields;
		t_edge_a;
		t_edge_b;
		final_report;
	end
	// Whole sequence needs well under 2000 ns
	initial
	begin
		#20000;
		mismatches++;
		final_report;
	end
endmodule
